// [bench/core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module core_model
  import core_regs_pkg::*;
(
  input wire logic clk_in,
  output logic [6:0] dir_addr_in,
  output logic [7:0] alu_a_in,
  output logic [7:0] alu_b_in,
  output var alu_op_t alu_op_in,
  output logic [7:0] logic_result_in,
  output logic write_en_in,
  output logic flags_en_in,
  output logic wdt_clear_in,
  output logic sleep_in,
  output logic wdt_timeout_in,
  output logic [2:0] irq_events_in,
  output logic read_en_in
);
  initial begin
    {dir_addr_in, alu_a_in, alu_b_in, logic_result_in, write_en_in, flags_en_in} = '0;
    {wdt_clear_in, sleep_in, wdt_timeout_in, irq_events_in, read_en_in} = '0;
    alu_op_in = OP_NONE;
  end
  // Requests change just after an edge and span exactly one sampling edge
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  task automatic op(input logic [6:0] ad, input alu_op_t o, input logic [7:0] a, b,
      input logic we, fe);
    step();
    {dir_addr_in, alu_a_in, alu_b_in, logic_result_in} = {ad, a, b, a & b};
    alu_op_in = o;
    {write_en_in, flags_en_in} = {we, fe};
    step();
    {write_en_in, flags_en_in} = '0;
    alu_op_in = OP_NONE;
  endtask
  task automatic mov(input logic [6:0] ad, input logic [7:0] d);
    logic [7:0] v;
    v = (ad == 7'h03) ? d & 8'h3F : d;
    op(ad, OP_MOVE, v, v, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [6:0] ad);
    step();
    {dir_addr_in, read_en_in} = {ad, 1'b1};
    step();
    read_en_in = 1'b0;
  endtask
  task automatic ev(input logic [5:0] e);
    step();
    {wdt_clear_in, sleep_in, wdt_timeout_in, irq_events_in} = e;
    step();
    {wdt_clear_in, sleep_in, wdt_timeout_in, irq_events_in} = '0;
  endtask
endmodule
`default_nettype wire

// [bench/core_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module core_regs_chk
  import core_regs_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [6:0] dir_addr_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire alu_op_t alu_op_in,
  input wire logic write_en_in,
  input wire logic flags_en_in,
  input wire logic wdt_clear_in,
  input wire logic sleep_in,
  input wire logic wdt_timeout_in,
  input wire logic read_en_in,
  input wire logic [7:0] read_data_out,
  input wire logic [7:0] status_out,
  input wire option_cfg_t option_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic sub;
  logic [7:0] opb;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [2:0] flags, evd;
  // Subtract adds the complement, so carries read as inverted borrows
  assign sub = alu_op_in == OP_SUB;
  assign opb = sub ? ~alu_b_in : alu_b_in;
  assign sum = alu_a_in + opb + 9'(sub);
  assign nib = alu_a_in[3:0] + opb[3:0] + 5'(sub);
  assign flags = {sum[7:0] == 8'h00, nib[4], sum[8]};
  always_ff @(posedge clk_in or posedge reset_in)
    if (reset_in) evd <= '0;
    else evd <= {evd[1:0], wdt_clear_in | sleep_in | wdt_timeout_in};
  sequence clr_st_s;
    write_en_in && flags_en_in && alu_op_in == OP_CLEAR && dir_addr_in == 7'h03;
  endsequence
  flag_ro_a: assert property ($changed(status_out[4:3]) |-> |evd)
    else $error("reset flags changed with no event");
  timeout_a: assert property (wdt_timeout_in |-> ##2 !status_out[4])
    else $error("timeout flag not cleared");
  sleep_pd_a: assert property (sleep_in && !wdt_timeout_in
      |-> ##2 status_out[4:3] == 2'b10)
    else $error("sleep flags wrong");
  wdt_clr_a: assert property (wdt_clear_in && !sleep_in && !wdt_timeout_in
      |-> ##2 status_out[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  arith_a: assert property (flags_en_in && alu_op_in inside {OP_ADD, OP_SUB}
      |-> ##2 status_out[2:0] == $past(flags, 2))
    else $error("arithmetic flags wrong");
  clr_st_a: assert property (clr_st_s |-> ##2 status_out[7:5] == 3'h0 && status_out[2])
    else $error("clear of status wrong");
  unimpl_a: assert property (read_en_in
      && dir_addr_in inside {[7'h06:7'h09], [7'h60:7'h7F]} |-> ##1 read_data_out == 8'h00)
    else $error("unimplemented read not zero");
  ratio_a: assert property ($onehot(option_out.watchdog_ratio)
      && option_out.timer0_ratio == {option_out.watchdog_ratio, 1'b0})
    else $error("prescaler ratios inconsistent");
endmodule
bind core_status_option_regs core_regs_chk u_chk (.*);
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import core_regs_pkg::*;
;
  logic clk_in, reset_in, write_en_in, flags_en_in, wdt_clear_in, sleep_in, wdt_timeout_in;
  logic read_en_in, irq_out, rd_d;
  logic [6:0] dir_addr_in;
  logic [2:0] irq_events_in;
  logic [7:0] alu_a_in, alu_b_in, logic_result_in, read_data_out, status_out, pc_low_out;
  logic [7:0] pc_high_out, irq_ctrl_out, r;
  alu_op_t alu_op_in;
  option_cfg_t option_out;
  logic [7:0] exp_q[$];
  int error_cnt, checks;
  core_status_option_regs u_dut (.*);
  core_model u_core (.*);
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [6:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    u_core.rd(ad);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rd_d) chk(read_data_out, exp_q.pop_front());
    rd_d <= read_en_in;
  end
  // Run needs under two hundred cycles; this is far beyond
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rd_d, reset_in} = 2'b01;
    void'($urandom(92));
    repeat (8) @(posedge clk_in);
    #1 reset_in = 1'b0;
    rd(7'h03, RESET_STATUS);
    rd(7'h02, 8'h00);
    rd(7'h0B, 8'h00);
    rd(7'h06, 8'h00);
    rd(7'h7F, 8'h00);
    u_core.mov(7'h03, 8'h07);
    rd(7'h03, 8'h1F);
    u_core.op(7'h03, OP_ADD, 8'h80, 8'h80, 1'b1, 1'b1);
    rd(7'h03, 8'h1D);
    $display("status test done");
    u_core.mov(7'h03, 8'h20);
    rd(7'h03, 8'h38);
    rd(7'h01, RESET_OPTION);
    for (int n = 0; n < 8; n++) begin
      r = 8'($urandom);
      r[2:0] = 3'(n);
      u_core.mov(7'h01, r);
      repeat (2) @(posedge clk_in);
      #1;
      chk(option_out, {r[7:3], 9'(2) << n, 8'(1) << n});
    end
    u_core.mov(7'h01, 8'h08);
    u_core.op(7'h03, OP_CLEAR, 8'h00, 8'h00, 1'b1, 1'b1);
    rd(7'h03, 8'h1C);
    rd(7'h01, 8'h00);
    $display("bank and option test done");
    r = 8'($urandom);
    u_core.mov(7'h20, r);
    u_core.mov(7'h04, 8'h20);
    rd(7'h00, r);
    u_core.mov(7'h03, 8'h20);
    rd(7'h20, r);
    rd(7'h04, 8'h20);
    rd(7'h00, r);
    u_core.mov(7'h04, 8'h06);
    rd(7'h00, 8'h00);
    u_core.mov(7'h03, 8'h00);
    u_core.mov(7'h02, 8'h5A);
    u_core.mov(7'h0A, 8'hFF);
    repeat (2) @(posedge clk_in);
    #1;
    chk(pc_low_out, 8'h5A);
    chk(pc_high_out, 8'h1F);
    rd(7'h0A, 8'h1F);
    $display("indirect test done");
    u_core.op(7'h20, OP_SUB, 8'h05, 8'h05, 1'b0, 1'b1);
    rd(7'h03, 8'h1F);
    repeat (16) u_core.op(7'h20, $urandom % 2 ? OP_ADD : OP_SUB, 8'($urandom),
        8'($urandom), 1'b0, 1'b1);
    u_core.mov(7'h03, 8'h00);
    u_core.op(7'h20, OP_ROR, 8'h01, 8'h00, 1'b0, 1'b1);
    rd(7'h03, 8'h19);
    u_core.op(7'h20, OP_ROL, 8'h7F, 8'h00, 1'b0, 1'b1);
    rd(7'h03, 8'h18);
    u_core.ev(6'h08);
    rd(7'h03, 8'h08);
    u_core.ev(6'h10);
    rd(7'h03, 8'h10);
    u_core.ev(6'h20);
    rd(7'h03, 8'h18);
    $display("flag test done");
    u_core.mov(7'h0B, 8'h00);
    u_core.ev(6'h04);
    rd(7'h0B, 8'h04);
    u_core.mov(7'h0B, 8'h24);
    repeat (3) @(posedge clk_in);
    #1;
    chk(irq_out, 1'b0);
    u_core.mov(7'h0B, 8'h00);
    u_core.mov(7'h0B, 8'hA0);
    u_core.ev(6'h04);
    repeat (3) @(posedge clk_in);
    #1;
    chk(irq_out, 1'b1);
    chk(irq_ctrl_out, 8'hA4);
    $display("interrupt test done");
    final_report();
  end
endmodule
`default_nettype wire

// [hdl/core_regs_pkg.sv]
package core_regs_pkg;
  localparam logic [7:0] ADDR_INDIRECT = 8'h00;
  localparam logic [7:0] ADDR_PC_LOW = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_POINTER = 8'h04;
  localparam logic [7:0] ADDR_PC_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_GPR_LO = 8'h20;
  localparam logic [7:0] ADDR_GPR_HI = 8'h5F;
  localparam int BIT_BANK = 5;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWERDOWN = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_DC = 1;
  localparam int BIT_CARRY = 0;
  localparam int BIT_PULLUP_DIS = 7;
  localparam int BIT_INT_EDGE = 6;
  localparam int BIT_T0_SOURCE = 5;
  localparam int BIT_T0_EDGE = 4;
  localparam int BIT_PS_ASSIGN = 3;
  localparam int BIT_GIE = 7;
  localparam logic [7:0] RESET_PC_LOW = 8'h00;
  localparam logic [7:0] RESET_PC_HIGH = 8'h00;
  localparam logic [7:0] RESET_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RESET_OPTION = 8'hFF;
  localparam logic [7:0] RESET_STATUS = 8'h18;
  localparam logic [7:0] PC_HIGH_MASK = 8'h1F;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ADD = 3'h1,
    OP_SUB = 3'h3,
    OP_LOGIC = 3'h2,
    OP_ROR = 3'h6,
    OP_ROL = 3'h7,
    OP_CLEAR = 3'h5,
    OP_MOVE = 3'h4
  } alu_op_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic pullup_disable_n;
    logic ext_int_rising;
    logic timer0_ext_source;
    logic timer0_falling;
    logic prescaler_to_watchdog;
    logic [8:0] timer0_ratio;
    logic [7:0] watchdog_ratio;
  } option_cfg_t;
endpackage

// [hdl/core_status_option_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (R1) Flag-updating ops override written Z, DC, C
// (R2) Software cannot write timeout or powerdown flags
// (R3) Clear on status: top cleared, Z set
// (R4) bank_select picks bank 0 or 1
// (R5) Timeout flag: set by power-up/clear/sleep, cleared by timeout
// (R6) Powerdown flag: set power-up/clear, cleared by sleep
// (R7) Zero flag follows result equals zero
// (R8) Digit carry from bit 3 carry
// (R9) Carry from most significant bit carry
// (R10) Subtract adds two's complement of operand
// (R11) Rotates load carry with shifted-out bit
// (R12) Software keeps reserved status bits zero
// (R13) pullup_disable_n high disables all pull-ups
// (R14) Edge select chooses external interrupt edge
// (R15) Source select picks pin or instruction clock
// (R16) Timer0 edge select picks pin edge
// (R17) Prescaler goes to watchdog or timer0
// (R18) Rate code divides by two-power ratios
// (R19) Software assigns prescaler to watchdog for 1:1
// (R20) Interrupt flags set regardless of enables
// (R21) Software clears flags before enabling sources
// (R22) Status mirrored at 03h and 83h
// (R23) Indirect port redirects through pointer
// (R24) Unimplemented locations read as zero
// (R25) Global enable gates all interrupts
// (R26) Core registers decoded in both banks, except option (bank 1 only)
// (R27) Reset loads listed core register values
module core_status_option_regs
  import core_regs_pkg::*;
#(
  parameter int GPR_DEPTH = 64
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [6:0] dir_addr_in,
  input wire logic [7:0] alu_a_in,
  input wire logic [7:0] alu_b_in,
  input wire alu_op_t alu_op_in,
  input wire logic [7:0] logic_result_in,
  input wire logic write_en_in,
  input wire logic flags_en_in,
  input wire logic wdt_clear_in,
  input wire logic sleep_in,
  input wire logic wdt_timeout_in,
  input wire logic [2:0] irq_events_in,
  input wire logic read_en_in,
  output logic [7:0] read_data_out,
  output logic [7:0] status_out,
  output logic [7:0] pc_low_out,
  output logic [7:0] pc_high_out,
  output logic [7:0] irq_ctrl_out,
  output logic irq_out,
  output option_cfg_t option_out
);

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] status;
  logic [7:0] pointer;
  logic [7:0] pc_low;
  logic [7:0] pc_high;
  logic [7:0] irq_ctrl;
  logic [7:0] option;
  logic [7:0] gpr [GPR_DEPTH];
  logic [7:0] eff_addr;
  logic [7:0] core_addr;
  logic [7:0] result;
  logic next_carry;
  logic next_dc;
  logic next_zero;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] operand_b;
  reg_write_t wr;

  // Bank bit forms address bit 7 for direct access
  always_comb begin
    if (dir_addr_in == ADDR_INDIRECT[6:0]) begin
      eff_addr = pointer; // (R23)
    end else begin
      eff_addr = {status[BIT_BANK], dir_addr_in}; // (R4)
    end
  end

  // Core registers ignore the bank bit, option excepted
  always_comb begin
    if (eff_addr == ADDR_OPTION) begin
      core_addr = ADDR_OPTION;
    end else begin
      core_addr = {1'b0, eff_addr[6:0]}; // (R22) (R26)
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Subtract as a + ~b + 1 so both carries come from the adder
  always_comb begin
    operand_b = (alu_op_in == OP_SUB) ? ~alu_b_in : alu_b_in; // (R10)
    sum = {1'b0, alu_a_in} + {1'b0, operand_b} + {8'h00, alu_op_in == OP_SUB};
    low_sum = {1'b0, alu_a_in[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, alu_op_in == OP_SUB};
    next_carry = status[BIT_CARRY];
    next_dc = status[BIT_DC];
    case (alu_op_in)
      OP_ADD, OP_SUB: begin
        result = sum[7:0];
        next_carry = sum[8]; // (R9)
        next_dc = low_sum[4]; // (R8)
      end
      OP_ROR: begin
        result = {status[BIT_CARRY], alu_a_in[7:1]};
        next_carry = alu_a_in[0]; // (R11)
      end
      OP_ROL: begin
        result = {alu_a_in[6:0], status[BIT_CARRY]};
        next_carry = alu_a_in[7]; // (R11)
      end
      OP_CLEAR: result = 8'h00;
      OP_LOGIC: result = logic_result_in;
      OP_MOVE: result = alu_a_in;
      default: result = alu_a_in;
    endcase
    // Rotates move only the carry; zero stays as it was
    if (alu_op_in == OP_ROR || alu_op_in == OP_ROL) begin
      next_zero = status[BIT_ZERO];
    end else begin
      next_zero = (result == 8'h00); // (R7)
    end
    wr.valid = write_en_in;
    wr.addr = core_addr;
    wr.data = result;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status <= RESET_STATUS; // (R27)
    end else begin
      if (wr.valid && wr.addr == ADDR_STATUS) begin
        // Writes reach bank and reserved bits, and Z, DC, C unless flags_en_in; reset flags stay (R2)
        status[7:5] <= wr.data[7:5]; // (R3)
      end
      if (flags_en_in) begin
        status[BIT_ZERO] <= next_zero; // (R7) (R1)
        status[BIT_CARRY] <= next_carry; // (R1)
        status[BIT_DC] <= next_dc;
      end else if (wr.valid && wr.addr == ADDR_STATUS) begin
        status[BIT_ZERO] <= wr.data[BIT_ZERO];
        status[BIT_CARRY] <= wr.data[BIT_CARRY];
        status[BIT_DC] <= wr.data[BIT_DC];
      end
      // Timeout event wins if it meets a clear or sleep
      if (wdt_timeout_in) begin
        status[BIT_TIMEOUT] <= 1'b0; // (R5)
      end else if (wdt_clear_in || sleep_in) begin
        status[BIT_TIMEOUT] <= 1'b1; // (R5)
      end
      if (sleep_in) begin
        status[BIT_POWERDOWN] <= 1'b0; // (R6)
      end else if (wdt_clear_in) begin
        status[BIT_POWERDOWN] <= 1'b1; // (R6)
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pointer <= 8'h00;
      pc_low <= RESET_PC_LOW; // (R27)
      pc_high <= RESET_PC_HIGH;
      option <= RESET_OPTION;
    end else if (wr.valid) begin
      case (wr.addr)
        ADDR_POINTER: pointer <= wr.data;
        ADDR_PC_LOW: pc_low <= wr.data;
        ADDR_PC_HIGH: pc_high <= wr.data & PC_HIGH_MASK;
        ADDR_OPTION: option <= wr.data;
        default: pointer <= pointer;
      endcase
    end
  end

  // Hardware flag sets win over a same-cycle software clear
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_ctrl <= RESET_IRQ_CTRL;
    end else begin
      if (wr.valid && wr.addr == ADDR_IRQ_CTRL) begin
        irq_ctrl <= wr.data | {5'h00, irq_events_in}; // (R20)
      end else begin
        irq_ctrl <= irq_ctrl | {5'h00, irq_events_in}; // (R20)
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr.valid && wr.addr >= ADDR_GPR_LO && wr.addr <= ADDR_GPR_HI) begin
      gpr[wr.addr[5:0]] <= wr.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      read_data_out <= 8'h00;
    end else if (read_en_in) begin
      if (eff_addr == ADDR_INDIRECT || eff_addr == 8'h80) begin
        read_data_out <= 8'h00;
      end else if (core_addr >= ADDR_GPR_LO && core_addr <= ADDR_GPR_HI) begin
        read_data_out <= gpr[core_addr[5:0]];
      end else begin
        case (core_addr)
          ADDR_STATUS: read_data_out <= status;
          ADDR_POINTER: read_data_out <= pointer;
          ADDR_PC_LOW: read_data_out <= pc_low;
          ADDR_PC_HIGH: read_data_out <= pc_high;
          ADDR_IRQ_CTRL: read_data_out <= irq_ctrl;
          ADDR_OPTION: read_data_out <= option;
          default: read_data_out <= 8'h00; // (R24)
        endcase
      end
    end
  end

  // Per-source enables sit at bits 5..3 over flags 2..0
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
      status_out <= RESET_STATUS;
      pc_low_out <= RESET_PC_LOW;
      pc_high_out <= RESET_PC_HIGH;
      irq_ctrl_out <= RESET_IRQ_CTRL;
    end else begin
      irq_out <= irq_ctrl[BIT_GIE] && |(irq_ctrl[5:3] & irq_ctrl[2:0]); // (R25)
      status_out <= status;
      pc_low_out <= pc_low;
      pc_high_out <= pc_high;
      irq_ctrl_out <= irq_ctrl;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      option_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 9'h100, 8'h80};
    end else begin
      option_out.pullup_disable_n <= option[BIT_PULLUP_DIS]; // (R13)
      option_out.ext_int_rising <= option[BIT_INT_EDGE]; // (R14)
      option_out.timer0_ext_source <= option[BIT_T0_SOURCE]; // (R15)
      option_out.timer0_falling <= option[BIT_T0_EDGE]; // (R16)
      option_out.prescaler_to_watchdog <= option[BIT_PS_ASSIGN]; // (R17)
      option_out.timer0_ratio <= 9'h002 << option[2:0]; // (R18)
      option_out.watchdog_ratio <= 8'h01 << option[2:0]; // (R18)
    end
  end

endmodule
`default_nettype wire
